// File: pabm_defs.svh
// constants for the port a/b alternate function mux
// assumes inclusion by the package and the mux design file only
`ifndef PABM_DEFS_SVH
`define PABM_DEFS_SVH
// ----------------------------------------
// port geometry
// ----------------------------------------
`define PABM_PORT_WIDTH 8
`define PABM_TIMER_LO_PIN 4
`define PABM_PIN_T0A_T1C 7
`define PABM_PIN_T1B 6
`define PABM_PIN_T1A 5
`define PABM_PIN_T2A 4
// ----------------------------------------
// reset values
// ----------------------------------------
`define PABM_RST_BYTE 8'h00
`endif

// File: pabm_pkg.sv
// types for the port a/b alternate function mux
// assumes pabm_defs.svh sits beside it
`include "pabm_defs.svh"
`default_nettype none
package pabm_pkg;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic [`PABM_PORT_WIDTH-1:0] pabm_byte_t;
    // mode of the port a pins
    typedef enum logic {PABM_MODE_GPIO, PABM_MODE_XMEM} pabm_mode_t;
endpackage
`default_nettype wire

// File: pabm_port_mux.sv
// pin override logic for ports a and b: external memory bus on a, timers and pin change on b
// assumes port registers, timers and memory interface share clk; pin inputs are asynchronous
//
// Overview of operation
// - port a pin n carries muxed addr/data bit n
// - memory enable overrides pullup, direction, value only
// - xmem driver on during write or address
// - address_active marks address phase on port a
// - pb7 shows timer0 compare a when output
// - pb7 alternatively shows timer1 compare c
// - pb6 shows timer1 compare b when output
// - pb5 shows timer1 compare a when output
// - pb4 shows timer2 compare a when output
// - pb7..pb4 feed pin change sources 7..4
// - pb3..pb1 are spi pins and pin-change sources
// - pb0 is spi select and source 0
// - pullup follows override, else input-latch-allowed rule
// - driver follows direction override, else direction bit
// - value follows override when override enabled, else latch
// - pb7..pb0 input enable forced by mask and group
`include "pabm_defs.svh"
`default_nettype none
module pabm_port_mux
    import pabm_pkg::*;
#(
    parameter int WIDTH = `PABM_PORT_WIDTH
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_mem_enable,
    input wire logic address_active,
    input wire logic write_strobe,
    input wire logic global_pullup_disable,
    input wire logic sleep_clamp,
    input wire logic [WIDTH-1:0] xmem_addr_low,
    input wire logic [WIDTH-1:0] xmem_data_out,
    output logic [WIDTH-1:0] xmem_data_in,
    input wire logic [WIDTH-1:0] port_a_out_latch,
    input wire logic [WIDTH-1:0] port_a_direction,
    input wire logic [WIDTH-1:0] port_a_pin_in,
    output logic [WIDTH-1:0] port_a_pin_out,
    output logic [WIDTH-1:0] port_a_pin_oe,
    output logic [WIDTH-1:0] port_a_pullup,
    output logic [WIDTH-1:0] port_a_sync_in,
    input wire logic [WIDTH-1:0] port_b_out_latch,
    input wire logic [WIDTH-1:0] port_b_direction,
    input wire logic [WIDTH-1:0] port_b_pin_in,
    output logic [WIDTH-1:0] port_b_pin_out,
    output logic [WIDTH-1:0] port_b_pin_oe,
    output logic [WIDTH-1:0] port_b_pullup,
    output logic [WIDTH-1:0] port_b_sync_in,
    input wire logic timer0_compare_a_en,
    input wire logic timer0_compare_a_out,
    input wire logic timer1_compare_c_en,
    input wire logic timer1_compare_c_out,
    input wire logic timer1_compare_b_en,
    input wire logic timer1_compare_b_out,
    input wire logic timer1_compare_a_en,
    input wire logic timer1_compare_a_out,
    input wire logic timer2_compare_a_en,
    input wire logic timer2_compare_a_out,
    input wire logic [WIDTH-1:0] pin_change_mask,
    input wire logic pin_change_group0_enable,
    output logic [WIDTH-1:0] pin_change_source,
    output logic spi_miso_in,
    output logic spi_mosi_in,
    output logic spi_sck_in,
    output logic spi_select_in,
    output logic [WIDTH-1:0] port_a_input_en,
    output logic [WIDTH-1:0] port_b_input_en
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // pin positions of the timer outputs are fixed at 4..7
    // any other width would leave timer pins dangling or out of range
    if (WIDTH != `PABM_PORT_WIDTH)
    begin : g_width_chk
        $error("pabm_port_mux: WIDTH must be 8");
    end

    // ----------------------------------------
    // generic override resolution
    // ----------------------------------------
    // the three helpers mirror the override cell that every pin carries
    // pullup: override value wins, else input with latch high and pullups allowed
    function automatic logic pabm_pullup(input logic ovr_en, input logic ovr_val, input logic dir,
                                         input logic latch, input logic pull_off);
        pabm_pullup = ovr_en ? ovr_val : (!dir && latch && !pull_off);
    endfunction

    // driver enable: direction override or the direction bit
    function automatic logic pabm_drive(input logic ovr_en, input logic ovr_val, input logic dir);
        pabm_drive = ovr_en ? ovr_val : dir;
    endfunction

    // pin value: override only matters while driving
    function automatic logic pabm_value(input logic ovr_en, input logic ovr_val, input logic latch);
        pabm_value = ovr_en ? ovr_val : latch;
    endfunction

    // ----------------------------------------
    // pin input synchronisers
    // ----------------------------------------
    pabm_byte_t a_meta, a_sync, b_meta, b_sync;
    pabm_byte_t next_a_meta, next_a_sync, next_b_meta, next_b_sync;

    // two stages trade two cycles of latency for metastability margin
    // both stages reset low, so synced outputs read zero until two edges pass
    // the first stage feeds only the second; everything else reads the second
    always_comb
    begin
        next_a_meta = port_a_pin_in;
        next_a_sync = a_meta;
        next_b_meta = port_b_pin_in;
        next_b_sync = b_meta;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            a_meta <= `PABM_RST_BYTE;
            a_sync <= `PABM_RST_BYTE;
            b_meta <= `PABM_RST_BYTE;
            b_sync <= `PABM_RST_BYTE;
        end
        else
        begin
            a_meta <= next_a_meta;
            a_sync <= next_a_sync;
            b_meta <= next_b_meta;
            b_sync <= next_b_sync;
        end
    end

    // ----------------------------------------
    // port a: gpio or multiplexed memory bus
    // ----------------------------------------
    pabm_mode_t a_mode;
    logic a_bus_drive;

    // address_active comes from the memory interface, already marking the address phase
    assign a_mode = ext_mem_enable ? PABM_MODE_XMEM : PABM_MODE_GPIO;
    assign a_bus_drive = write_strobe || address_active;

    // both strobes at once is not expected; the value is then the or of both
    // combinational outputs; data path stays registered upstream in the memory interface
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            port_a_pullup[i] = pabm_pullup(a_mode == PABM_MODE_XMEM,
                                           !a_bus_drive && port_a_out_latch[i] && !global_pullup_disable,
                                           port_a_direction[i], port_a_out_latch[i],
                                           global_pullup_disable);
            port_a_pin_oe[i] = pabm_drive(a_mode == PABM_MODE_XMEM, a_bus_drive,
                                          port_a_direction[i]);
            port_a_pin_out[i] = pabm_value(a_mode == PABM_MODE_XMEM,
                                           (xmem_addr_low[i] && address_active)
                                           || (xmem_data_out[i] && write_strobe),
                                           port_a_out_latch[i]);
        end
    end

    // input enable never overridden on port a: only sleep clamps it
    assign port_a_input_en = {WIDTH{!sleep_clamp}};
    // read data is the synced pad, so the memory interface sees it two edges late
    assign port_a_sync_in = a_sync;
    assign xmem_data_in = a_sync;

    // ----------------------------------------
    // port b: timer outputs and pin change
    // ----------------------------------------
    logic [WIDTH-1:0] b_val_en, b_val;

    // pb3..pb0 keep gpio direction and value: spi overrides are not built here
    // pb7 shares timer0 a and timer1 c; ored like the compare units do
    // software is expected to enable only one of the two units on pb7
    always_comb
    begin
        b_val_en = '0;
        b_val = '0;
        b_val_en[`PABM_PIN_T0A_T1C] = timer0_compare_a_en || timer1_compare_c_en;
        b_val[`PABM_PIN_T0A_T1C] = (timer0_compare_a_en && timer0_compare_a_out)
                                 || (timer1_compare_c_en && timer1_compare_c_out);
        b_val_en[`PABM_PIN_T1B] = timer1_compare_b_en;
        b_val[`PABM_PIN_T1B] = timer1_compare_b_out;
        b_val_en[`PABM_PIN_T1A] = timer1_compare_a_en;
        b_val[`PABM_PIN_T1A] = timer1_compare_a_out;
        b_val_en[`PABM_PIN_T2A] = timer2_compare_a_en;
        b_val[`PABM_PIN_T2A] = timer2_compare_a_out;
    end

    // direction is never overridden, so timers need the direction bit set
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            port_b_pullup[i] = pabm_pullup(1'b0, 1'b0, port_b_direction[i],
                                           port_b_out_latch[i], global_pullup_disable);
            port_b_pin_oe[i] = pabm_drive(1'b0, 1'b0, port_b_direction[i]);
            port_b_pin_out[i] = pabm_value(b_val_en[i], b_val[i], port_b_out_latch[i]);
            // masked pin change with group0 enabled keeps the input alive through sleep
            port_b_input_en[i] = (pin_change_mask[i] && pin_change_group0_enable)
                                 || !sleep_clamp;
        end
    end

    // edge detection on the pin change sources lives in the interrupt block
    // spi inputs come after the synchroniser like every other consumer
    // every pin feeds its pin change source; spi reads low pins
    assign pin_change_source = b_sync;
    assign port_b_sync_in = b_sync;
    assign spi_miso_in = b_sync[3];
    assign spi_mosi_in = b_sync[2];
    assign spi_sck_in = b_sync[1];
    assign spi_select_in = b_sync[0];
endmodule
`default_nettype wire

// File: pabm_port_mux_monitor.sv
// pin relation checks for the port a/b override mux
// assumes it is bound onto pabm_port_mux with one clock
`default_nettype none
module pabm_port_mux_monitor
    import pabm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_mem_enable,
    input wire logic address_active,
    input wire logic write_strobe,
    input wire logic global_pullup_disable,
    input wire pabm_byte_t xmem_addr_low,
    input wire pabm_byte_t xmem_data_out,
    input wire pabm_byte_t xmem_data_in,
    input wire pabm_byte_t port_a_out_latch,
    input wire pabm_byte_t port_a_direction,
    input wire pabm_byte_t port_a_pin_in,
    input wire pabm_byte_t port_a_pin_out,
    input wire pabm_byte_t port_a_pin_oe,
    input wire pabm_byte_t port_a_pullup,
    input wire pabm_byte_t port_b_pin_in,
    input wire pabm_byte_t pin_change_source
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // either strobe means the device owns port a
    wire logic busy = write_strobe | address_active;
    wire pabm_byte_t pu_ok = port_a_out_latch & {8{~global_pullup_disable}};
    chk_xmem_drive: assert property (ext_mem_enable |-> port_a_pin_oe == {8{busy}}) else $error("oe");
    chk_xmem_addr: assert property (ext_mem_enable && address_active && !write_strobe
        |-> port_a_pin_out == xmem_addr_low) else $error("addr");
    chk_xmem_data: assert property (ext_mem_enable && write_strobe && !address_active
        |-> port_a_pin_out == xmem_data_out) else $error("data");
    chk_xmem_pull: assert property (ext_mem_enable |-> port_a_pullup == (pu_ok & {8{~busy}})) else $error("pu");
    chk_gpio_drive: assert property (!ext_mem_enable |-> port_a_pin_oe == port_a_direction
        && port_a_pin_out == port_a_out_latch) else $error("gpio");
    chk_gpio_pull: assert property (!ext_mem_enable |-> port_a_pullup == (pu_ok & ~port_a_direction)) else $error("gp");
    // sync pipe: first two edges after reset still hold reset zeros
    chk_read_sync: assert property (!$past(rst) && !$past(rst, 2) |->
        xmem_data_in == $past(port_a_pin_in, 2)) else $error("rd");
    chk_change_sync: assert property (!$past(rst) && !$past(rst, 2) |->
        pin_change_source == $past(port_b_pin_in, 2)) else $error("pc");
    cover property (ext_mem_enable && write_strobe);
    cover property (ext_mem_enable && address_active);
    cover property ($changed(pin_change_source));
endmodule
bind pabm_port_mux pabm_port_mux_monitor mon (.*);
`default_nettype wire

// File: pabm_xmem_model.sv
// external memory on the muxed port a bus
// assumes the bench hands it the strobes and the port a pads
`default_nettype none
module pabm_xmem_model
    import pabm_pkg::*;
(
    input wire logic clk,
    input wire logic ale,
    input wire logic wr,
    input wire logic rd,
    input wire pabm_byte_t oe,
    input wire pabm_byte_t dout,
    input wire pabm_byte_t pull_en,
    output var pabm_byte_t din
);
    timeunit 1ns;
    timeprecision 1ns;
    pabm_byte_t mem [256];
    pabm_byte_t addr = '0;
    pabm_byte_t pat = 8'h55;
    // floating pads toggle so stale bus data never passes as a read
    assign din = (oe & dout) | (~oe & (rd ? mem[addr] : (pull_en | pat)));
    // address taken in the address phase, data on the write strobe
    always @(posedge clk)
    begin
        pat <= ~pat;
        if (ale)
            addr <= din;
        if (wr)
            mem[addr] <= din;
    end
endmodule
`default_nettype wire

// File: pabm_port_mux_tb_top.sv
// self-checking bench for the port a/b override mux
// assumes the monitor binds itself and the memory model sits on port a
`default_nettype none
module pabm_port_mux_tb_top
    import pabm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = '0, rst = 1'b1, ext_mem_enable = '0, address_active = '0, write_strobe = '0, rd = '0;
    logic global_pullup_disable = '0, sleep_clamp = '0, pin_change_group0_enable = '0;
    logic timer0_compare_a_en = '0, timer1_compare_c_en = '0, timer1_compare_b_en = '0, timer1_compare_a_en = '0;
    logic timer2_compare_a_en = '0, timer0_compare_a_out = '0, timer1_compare_c_out = '0, timer1_compare_b_out = '0;
    logic timer1_compare_a_out = '0, timer2_compare_a_out = '0, spi_miso_in, spi_mosi_in, spi_sck_in, spi_select_in;
    pabm_byte_t xmem_addr_low = '0, xmem_data_out = '0, port_a_out_latch = '0, port_a_direction = '0;
    pabm_byte_t port_b_out_latch = '0, port_b_direction = '0, port_b_pin_in = '0, pin_change_mask = '0;
    pabm_byte_t port_a_pin_in, xmem_data_in, port_a_pin_out, port_a_pin_oe, port_a_pullup, port_a_sync_in;
    pabm_byte_t port_b_pin_out, port_b_pin_oe, port_b_pullup, port_b_sync_in, pin_change_source;
    pabm_byte_t port_a_input_en, port_b_input_en;
    int fail_count = 0, cmp_count = 0;
    pabm_port_mux dut (.*);
    pabm_xmem_model mem_model (.clk, .ale(address_active), .wr(write_strobe), .rd, .oe(port_a_pin_oe),
        .dout(port_a_pin_out), .pull_en(port_a_pullup), .din(port_a_pin_in));
    initial forever #20 clk = ~clk;
    task automatic chk(input pabm_byte_t got, input pabm_byte_t exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic t_write();
        @(posedge clk);
        {ext_mem_enable, address_active, xmem_addr_low} <= {2'h3, 8'hA5};
        @(negedge clk);
        chk(port_a_pin_out, 8'hA5);
        chk(port_a_input_en, 8'hFF);
        @(posedge clk);
        {address_active, write_strobe, xmem_data_out} <= {2'h1, 8'h3C};
        @(negedge clk);
        chk(port_a_pin_out, 8'h3C);
        chk(port_a_pin_oe, 8'hFF);
        @(posedge clk);
        write_strobe <= 1'b0;
        @(negedge clk);
        chk(port_a_pin_oe, 8'h00);
        $display("write test over");
    endtask
    task automatic t_read();
        @(posedge clk);
        {address_active, port_a_out_latch} <= {1'b1, 8'h0F};
        @(posedge clk);
        {address_active, rd} <= 2'h1;
        repeat (3) @(negedge clk);
        chk(port_a_pullup, 8'h0F);
        chk(xmem_data_in, 8'h3C);
        chk(port_a_sync_in, 8'h3C);
        @(posedge clk);
        {global_pullup_disable, rd} <= 2'h2;
        @(negedge clk);
        chk(port_a_pullup, 8'h00);
        $display("read test over");
    endtask
    task automatic t_gpio();
        @(posedge clk);
        {ext_mem_enable, global_pullup_disable, port_a_direction} <= {2'h0, 8'hC3};
        @(negedge clk);
        chk(port_a_pin_oe, 8'hC3);
        chk(port_a_pin_out, 8'h0F);
        chk(port_a_pullup, 8'h0C);
        $display("gpio test over");
    endtask
    task automatic t_timers();
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            {timer0_compare_a_en, timer1_compare_c_en, timer1_compare_b_en, timer1_compare_a_en,
                timer2_compare_a_en} <= 5'h10 >> i;
            {port_b_direction, port_b_out_latch} <= {8'hF0, 8'hFF};
            {timer0_compare_a_out, timer1_compare_c_out, timer1_compare_b_out, timer1_compare_a_out,
                timer2_compare_a_out} <= 5'h00;
            @(negedge clk);
            chk(port_b_pin_out, 8'hFF ^ (8'h80 >> (i == 0 ? 0 : i - 1)));
            chk(port_b_pin_oe, 8'hF0);
            chk(port_b_pullup, 8'h0F);
            @(posedge clk);
            port_b_out_latch <= 8'h00;
            {timer0_compare_a_out, timer1_compare_c_out, timer1_compare_b_out, timer1_compare_a_out,
                timer2_compare_a_out} <= 5'h1F;
            @(negedge clk);
            chk(port_b_pin_out, 8'h80 >> (i == 0 ? 0 : i - 1));
            chk(port_b_pullup, 8'h00);
        end
        $display("timer test over");
    endtask
    task automatic t_change();
        @(posedge clk);
        {port_b_pin_in, sleep_clamp, pin_change_mask, pin_change_group0_enable} <= {8'hA6, 1'b1, 8'hF0, 1'b1};
        repeat (3) @(negedge clk);
        chk(port_b_input_en, 8'hF0);
        chk(pin_change_source, 8'hA6);
        chk(port_b_sync_in, 8'hA6);
        chk(port_a_input_en, 8'h00);
        chk({4'h0, spi_miso_in, spi_mosi_in, spi_sck_in, spi_select_in}, 8'h06);
        @(posedge clk);
        pin_change_group0_enable <= 1'b0;
        @(negedge clk);
        chk(port_b_input_en, 8'h00);
        $display("pin change test over");
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_write();
        t_read();
        t_gpio();
        t_timers();
        t_change();
        test_done();
    end
    // tests need about 35 cycles; the 500-cycle limit, over ten times that, means a hang
    initial
    begin
        #20000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
